/* design/ssrs_regs.vh */
// Register offsets, field positions, reset values and timing counts for the supply supervisor
`ifndef SSRS_REGS_VH
`define SSRS_REGS_VH
`define SSRS_ADDR_CTRL 4'h0
`define SSRS_ADDR_STATUS 4'h4
`define SSRS_ADDR_IRQ_STAT 4'h8
`define SSRS_ADDR_IRQ_MASK 4'hC
`define SSRS_CTRL_MR_LOW 0
`define SSRS_CTRL_SW_EN 1
`define SSRS_CTRL_SW_AUTO 2
`define SSRS_CTRL_UV_LSB 4
`define SSRS_CTRL_UV_MSB 7
`define SSRS_CTRL_RESET 32'h0000_0084
`define SSRS_ST_PRIM 0
`define SSRS_ST_BUS 1
`define SSRS_ST_SRC_PRIM 2
`define SSRS_ST_DEAD_BAT 3
`define SSRS_ST_UV 4
`define SSRS_ST_MR 5
`define SSRS_ST_SW_ON 6
`define SSRS_ST_POWER_OK 7
`define SSRS_EV_HARD_RESET 0
`define SSRS_EV_DEAD_BAT 1
`define SSRS_EV_UV 2
`define SSRS_EV_SWITCH_OVER 3
`define SSRS_HARD_RESET_NS 1000
`define SSRS_CLK_NS 40
`endif

/* design/ssrs_sync.v */
// Three-stage input synchroniser bank with agreement filter
`timescale 1ns/1ps
module ssrs_sync #(
  parameter WIDTH = 4
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  reg [WIDTH-1:0] out_reg;
  genvar i;

  // Stage chain; first stage feeds only the second
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Change counts when second and third stages agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gAgree
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          out_reg[i] <= 1'b0;
        end else if (stage2_reg[i] == stage3_reg[i]) begin
          out_reg[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate

  assign syncOut = out_reg;
endmodule // ssrs_sync

/* design/ssrs_supervisor.v */
// Supply selection, hard reset and system reset supervisor with AXI4-Lite registers
`timescale 1ns/1ps
`include "ssrs_regs.vh"
// Notes on behaviour
// - System reset output low while aux output is under-voltage or manual reset is active, else high.
// - Manual reset asserted also drives system reset low, regardless of supervisor.
// - Manual reset active high after reset; control bit makes it active low.
// - Aux output switch enabled by core logic under programmable conditions.
// - Pull-down engaged on aux output whenever its switch is off.
// - Aux under-voltage threshold is programmable, separate from internal supervisors.
// - Active circuitry stays off until the internal rail and at least one input supply report good.
// - Both supplies present: primary input is the power source.
// - Primary absent, bus present: stepped-down bus supply is the source.
// - Primary appearing after bus switches over automatically, no reset.
// - Primary lost while both present: hard reset, then reboot.
// - Absent primary reported as dead-battery status.
module ssrs_supervisor #(
  parameter UV_WIDTH = 4,
  parameter HARD_RESET_NS = `SSRS_HARD_RESET_NS
) (
  input wire mclk,
  input wire rst,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire primarySupplyGood,
  input wire busSupplyGood,
  input wire internalRailGood,
  input wire auxUnderVoltage,
  input wire manualResetIn,
  output wire systemResetOut_n,
  output wire auxOutputSwitch,
  output wire auxOutputPulldown,
  output wire selectPrimary,
  output wire selectBus,
  output wire deadBattery,
  output wire [UV_WIDTH-1:0] auxUvThreshold,
  output wire coreEnable,
  output wire hardResetOut,
  output wire irq
);
  // Hard reset span in clock cycles, rounded up; five bits cover up to 31 cycles
  localparam integer HARD_RESET_CYC_I = (HARD_RESET_NS + `SSRS_CLK_NS - 1) / `SSRS_CLK_NS;
  localparam [4:0] HARD_RESET_CYC = HARD_RESET_CYC_I[4:0];
  // One-hot power states
  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_RUN = 4'h2;
  localparam [3:0] ST_HARD = 4'h4;
  localparam [3:0] ST_REBOOT = 4'h8;

  // Synchronised levels and derived conditions
  wire [4:0] syncIn;
  wire primGood;
  wire busGood;
  wire railGood;
  wire uvSync;
  wire mrSync;
  wire mrActive;
  wire anyGood;

  // Configuration, interrupt and power state registers
  reg [31:0] ctrl_reg;
  reg [3:0] irqStat_reg;
  reg [3:0] irqMask_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [4:0] hardCnt_reg;
  reg srcPrim_reg;
  reg srcBus_reg;
  reg primPrev_reg;
  reg uvPrev_reg;
  reg sysRstN_reg;
  reg swOn_reg;
  reg [3:0] events;

  // Bus channel state
  reg awDone_reg;
  reg wDone_reg;
  reg [31:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg bValid_reg;
  reg [1:0] bResp_reg;
  reg rValid_reg;
  reg [31:0] rData_reg;
  reg [1:0] rResp_reg;

  // Combinational helpers
  reg [31:0] statusWord;
  wire wrFire;
  wire rdFire;

  // Register select: upper address bits zero, low nibble equal to the offset
  function regHit;
    input [31:0] addr;
    input [3:0] offset;
    begin
      regHit = (addr[31:4] == 28'h0000000) && (addr[3:0] == offset);
    end
  endfunction

  // Synchronise every level from outside the clock domain
  ssrs_sync #(
    .WIDTH(5)
  ) uSync (
    .mclk(mclk),
    .rst(rst),
    .asyncIn({manualResetIn, auxUnderVoltage, internalRailGood, busSupplyGood, primarySupplyGood}),
    .syncOut(syncIn)
  );

  assign primGood = syncIn[0];
  assign busGood = syncIn[1];
  assign railGood = syncIn[2];
  assign uvSync = syncIn[3];
  assign mrSync = syncIn[4];
  assign anyGood = primGood | busGood;

  // Manual reset polarity from control bit
  assign mrActive = ctrl_reg[`SSRS_CTRL_MR_LOW] ? ~mrSync : mrSync;

  // Power state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (railGood && anyGood) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (primPrev_reg && !primGood && busGood && srcPrim_reg) begin
          state_next = ST_HARD;
        end else if (!railGood || !anyGood) begin
          state_next = ST_OFF;
        end
      end
      ST_HARD: begin
        if (hardCnt_reg == 5'h00) begin
          state_next = ST_REBOOT;
        end
      end
      ST_REBOOT: begin
        state_next = ST_OFF;
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // State, hard reset timer and source selection
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_OFF;
      hardCnt_reg <= 5'h00;
      srcPrim_reg <= 1'b0;
      srcBus_reg <= 1'b0;
      primPrev_reg <= 1'b0;
      uvPrev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      primPrev_reg <= primGood;
      uvPrev_reg <= uvSync;
      if (state_next == ST_HARD && state_reg != ST_HARD) begin
        hardCnt_reg <= HARD_RESET_CYC - 5'h01;
      end else if (hardCnt_reg != 5'h00) begin
        hardCnt_reg <= hardCnt_reg - 5'h01;
      end
      if (primGood) begin
        srcPrim_reg <= 1'b1;
        srcBus_reg <= 1'b0;
      end else begin
        srcPrim_reg <= 1'b0;
        srcBus_reg <= busGood;
      end
    end
  end

  // Aux switch and system reset output
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      swOn_reg <= 1'b0;
      sysRstN_reg <= 1'b0;
    end else begin
      swOn_reg <= (state_reg == ST_RUN) && primGood && ctrl_reg[`SSRS_CTRL_SW_EN]
        && (!ctrl_reg[`SSRS_CTRL_SW_AUTO] || srcPrim_reg);
      sysRstN_reg <= !(uvSync || mrActive);
    end
  end

  // Output levels from registers and state
  assign systemResetOut_n = sysRstN_reg;
  assign auxOutputSwitch = swOn_reg;
  assign auxOutputPulldown = ~swOn_reg;
  assign selectPrimary = srcPrim_reg;
  assign selectBus = srcBus_reg;
  assign deadBattery = ~srcPrim_reg;
  assign auxUvThreshold = ctrl_reg[`SSRS_CTRL_UV_LSB +: UV_WIDTH];
  assign coreEnable = (state_reg == ST_RUN);
  assign hardResetOut = (state_reg == ST_HARD) | (state_reg == ST_REBOOT);

  // Event sources for sticky status
  always @* begin
    events = 4'h0;
    events[`SSRS_EV_HARD_RESET] = (state_next == ST_HARD) && (state_reg != ST_HARD);
    events[`SSRS_EV_DEAD_BAT] = primPrev_reg && !primGood;
    events[`SSRS_EV_UV] = uvSync && !uvPrev_reg;
    events[`SSRS_EV_SWITCH_OVER] = !primPrev_reg && primGood && busGood;
  end

  // Level interrupt while any unmasked sticky bit is set
  assign irq = |(irqStat_reg & irqMask_reg);

  // AXI4-Lite write channel handshakes
  assign s_axi_awready = !awDone_reg && !bValid_reg;
  assign s_axi_wready = !wDone_reg && !bValid_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign wrFire = awDone_reg && wDone_reg && !bValid_reg;

  // Write address/data capture and response
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      awDone_reg <= 1'b0;
      wDone_reg <= 1'b0;
      awAddr_reg <= 32'h0000_0000;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awDone_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDone_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrFire) begin
        awDone_reg <= 1'b0;
        wDone_reg <= 1'b0;
        bValid_reg <= 1'b1;
        if (regHit(awAddr_reg, `SSRS_ADDR_CTRL) || regHit(awAddr_reg, `SSRS_ADDR_STATUS)
            || regHit(awAddr_reg, `SSRS_ADDR_IRQ_STAT) || regHit(awAddr_reg, `SSRS_ADDR_IRQ_MASK)) begin
          bResp_reg <= 2'h0;
        end else begin
          bResp_reg <= 2'h2;
        end
      end else if (bValid_reg && s_axi_bready) begin
        bValid_reg <= 1'b0;
      end
    end
  end

  // Control, mask and sticky status registers
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `SSRS_CTRL_RESET;
      irqMask_reg <= 4'h0;
      irqStat_reg <= 4'h0;
    end else begin
      if (wrFire && regHit(awAddr_reg, `SSRS_ADDR_CTRL) && wStrb_reg[0]) begin
        ctrl_reg[7:0] <= {wData_reg[7:4], 1'b0, wData_reg[2:0]};
      end
      if (wrFire && regHit(awAddr_reg, `SSRS_ADDR_IRQ_MASK) && wStrb_reg[0]) begin
        irqMask_reg <= wData_reg[3:0];
      end
      // Set wins over write-one-to-clear
      if (wrFire && regHit(awAddr_reg, `SSRS_ADDR_IRQ_STAT) && wStrb_reg[0]) begin
        irqStat_reg <= (irqStat_reg & ~wData_reg[3:0]) | events;
      end else begin
        irqStat_reg <= irqStat_reg | events;
      end
    end
  end

  // Live status word
  always @* begin
    statusWord = 32'h0000_0000;
    statusWord[`SSRS_ST_PRIM] = primGood;
    statusWord[`SSRS_ST_BUS] = busGood;
    statusWord[`SSRS_ST_SRC_PRIM] = srcPrim_reg;
    statusWord[`SSRS_ST_DEAD_BAT] = ~srcPrim_reg;
    statusWord[`SSRS_ST_UV] = uvSync;
    statusWord[`SSRS_ST_MR] = mrActive;
    statusWord[`SSRS_ST_SW_ON] = swOn_reg;
    statusWord[`SSRS_ST_POWER_OK] = coreEnable;
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;
  assign rdFire = s_axi_arvalid && !rValid_reg;

  // Read decode and data capture
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0000_0000;
      rResp_reg <= 2'h0;
    end else if (rdFire) begin
      rValid_reg <= 1'b1;
      rResp_reg <= 2'h0;
      if (s_axi_araddr[31:4] != 28'h0000000) begin
        rData_reg <= 32'h0000_0000;
        rResp_reg <= 2'h2;
      end else if (s_axi_araddr[3:0] == `SSRS_ADDR_CTRL) begin
        rData_reg <= ctrl_reg;
      end else if (s_axi_araddr[3:0] == `SSRS_ADDR_STATUS) begin
        rData_reg <= statusWord;
      end else if (s_axi_araddr[3:0] == `SSRS_ADDR_IRQ_STAT) begin
        rData_reg <= {28'h0000000, irqStat_reg};
      end else if (s_axi_araddr[3:0] == `SSRS_ADDR_IRQ_MASK) begin
        rData_reg <= {28'h0000000, irqMask_reg};
      end else begin
        rData_reg <= 32'h0000_0000;
        rResp_reg <= 2'h2;
      end
    end else if (rValid_reg && s_axi_rready) begin
      rValid_reg <= 1'b0;
    end
  end
endmodule // ssrs_supervisor

/* sim/ssrs_chk_asserts.sv */
// Checker for supply selection, hard reset and reset output
`timescale 1ns/1ps
module ssrs_chk #(
  parameter HARD_RESET_NS = 1000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic primarySupplyGood,
  input wire logic busSupplyGood,
  input wire logic internalRailGood,
  input wire logic auxUnderVoltage,
  input wire logic systemResetOut_n,
  input wire logic auxOutputSwitch,
  input wire logic auxOutputPulldown,
  input wire logic selectPrimary,
  input wire logic selectBus,
  input wire logic deadBattery,
  input wire logic coreEnable,
  input wire logic hardResetOut
);
  localparam int HrCyc = (HARD_RESET_NS + 40 - 1) / 40 + 1;
  logic [7:0] hiCnt_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Cycles the hard reset output has stood high
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hiCnt_reg <= 8'h00;
    end else begin
      hiCnt_reg <= hardResetOut ? hiCnt_reg + 8'h01 : 8'h00;
    end
  end
  pull_down_a: assert property (
    auxOutputPulldown == !auxOutputSwitch) else $error("pulldown wrong");
  dead_battery_a: assert property (
    deadBattery == !selectPrimary) else $error("dead battery wrong");
  hard_not_run_a: assert property (
    hardResetOut |-> !coreEnable && !auxOutputSwitch) else $error("core or switch on in hard reset");
  uv_holds_reset_a: assert property (
    auxUnderVoltage [*8] |-> !systemResetOut_n) else $error("reset not low on UV");
  rail_gates_core_a: assert property (
    !internalRailGood [*8] |-> !coreEnable) else $error("core on without rail");
  primary_wins_a: assert property (
    (primarySupplyGood && busSupplyGood) [*8] ##0 coreEnable |-> selectPrimary) else $error("primary not chosen");
  bus_fallback_a: assert property (
    (!primarySupplyGood && busSupplyGood) [*8] ##0 coreEnable |-> selectBus) else $error("bus not chosen");
  hard_length_a: assert property (
    $fell(hardResetOut) |-> hiCnt_reg == HrCyc) else $error("hard reset length");
  hard_cause_a: assert property (
    $rose(hardResetOut) |-> !primarySupplyGood && busSupplyGood) else $error("hard reset cause");
endmodule // ssrs_chk

bind ssrs_supervisor ssrs_chk #(.HARD_RESET_NS(HARD_RESET_NS)) u_chk (.*);

/* sim/ssrs_supply_model.sv */
// Board supplies and host reset switch with settling lag
`timescale 1ns/1ps
module ssrs_supply_model (
  input wire logic mclk,
  input wire logic [4:0] want,
  output wire logic primarySupplyGood,
  output wire logic busSupplyGood,
  output wire logic internalRailGood,
  output wire logic auxUnderVoltage,
  output wire logic manualResetIn
);
  logic [4:0] lag = 5'h00;
  logic [4:0] lvl = 5'h00;
  // Levels settle two edges after a request
  always @(posedge mclk) begin
    lag <= want;
    lvl <= lag;
  end
  assign {manualResetIn, auxUnderVoltage, internalRailGood, busSupplyGood, primarySupplyGood} = lvl;
endmodule // ssrs_supply_model

/* sim/tb_top.sv */
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
`include "ssrs_regs.vh"
module tb_top;
  logic mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, auxUvThreshold, t;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic primarySupplyGood, busSupplyGood, internalRailGood, auxUnderVoltage, manualResetIn;
  logic systemResetOut_n, auxOutputSwitch, auxOutputPulldown, selectPrimary, selectBus;
  logic deadBattery, coreEnable, hardResetOut, irq;
  logic [4:0] want;
  int failCount = 0, checkCount = 0, n;
  localparam int HardNs = 200;
  ssrs_supervisor #(.HARD_RESET_NS(HardNs)) u_dut (.*);
  ssrs_supply_model u_sup (.*);
  // Clock of 40 ns
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, exp, input string m);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s %h/%h", $time, m, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Write: address and data offered together
  task automatic axw(input logic [31:0] a, d);
    logic aw, w, b, ar, wr;
    aw = 1;
    w = 1;
    b = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (b) begin
      @(negedge mclk);
      ar = s_axi_awready;
      wr = s_axi_wready;
      b = !s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge mclk);
      s_axi_awvalid <= aw && !ar;
      aw = aw && !ar;
      s_axi_wvalid <= w && !wr;
      w = w && !wr;
      s_axi_bready <= b;
    end
    @(posedge mclk);
  endtask
  // Read: data and response land in rd and rsp
  task automatic axr(input logic [31:0] a);
    logic ar, r, g;
    ar = 1;
    r = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (r) begin
      @(negedge mclk);
      g = s_axi_arready;
      r = !s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge mclk);
      s_axi_arvalid <= ar && !g;
      ar = ar && !g;
      s_axi_rready <= r;
    end
    @(posedge mclk);
  endtask
  function automatic logic rstExp(input logic uv, mr, low);
    return !(uv || (mr ^ low));
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (6000) @(posedge mclk);
    failCount++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    void'($urandom(32'hC0E58DA5));
    rst = 1;
    want = 5'h00;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    repeat (8) @(posedge mclk);
    chk(auxOutputPulldown, 1, "pulldown");
    rst <= 0;
    @(posedge mclk);
    axr(`SSRS_ADDR_CTRL);
    chk(rd, `SSRS_CTRL_RESET, "ctrl reset");
    axr(32'h10);
    chk(rd, 32'h0, "unmapped data");
    chk(rsp, 2'h2, "unmapped read");
    axw(32'h14, 32'hF);
    chk(rsp, 2'h2, "unmapped write");
    want <= 5'h06;
    cyc(12);
    chk({selectBus, selectPrimary, deadBattery, coreEnable}, 4'hB, "bus source");
    axw(`SSRS_ADDR_IRQ_MASK, 32'hF);
    chk(rsp, 2'h0, "write okay");
    want <= 5'h07;
    cyc(12);
    chk({selectPrimary, deadBattery, hardResetOut, irq}, 4'h9, "switch-over");
    axr(`SSRS_ADDR_IRQ_STAT);
    chk(rd[`SSRS_EV_SWITCH_OVER], 1, "switch event");
    axw(`SSRS_ADDR_IRQ_STAT, 32'hF);
    cyc(2);
    chk(irq, 0, "irq clear");
    for (n = 0; n < 5; n++) begin
      t = (n == 0) ? 4'h0 : (n == 1) ? 4'hF : 4'($urandom);
      axw(`SSRS_ADDR_CTRL, {24'h0, t, 4'hE});
      cyc(3);
      chk({auxUvThreshold, auxOutputSwitch, auxOutputPulldown}, {t, 2'b10}, "switch on");
      axr(`SSRS_ADDR_CTRL);
      chk(rd, {24'h0, t, 4'h6}, "ctrl");
    end
    for (n = 0; n < 8; n++) begin
      axw(`SSRS_ADDR_CTRL, {31'h42, n[2]});
      want <= {n[1], n[0], 3'h7};
      cyc(12);
      chk({auxOutputSwitch, systemResetOut_n}, {1'b0, rstExp(n[0], n[1], n[2])}, "sys reset");
    end
    want <= 5'h07;
    cyc(12);
    want <= 5'h06;
    for (n = 0; n < 30 && hardResetOut !== 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 40 && hardResetOut === 1'b1; n++) @(negedge mclk);
    chk(n, (HardNs + `SSRS_CLK_NS - 1) / `SSRS_CLK_NS + 1, "hard length");
    cyc(15);
    chk({coreEnable, selectBus, irq}, 3'h7, "reboot");
    axr(`SSRS_ADDR_IRQ_STAT);
    chk(rd[`SSRS_EV_HARD_RESET], 1, "hard event");
    axr(`SSRS_ADDR_STATUS);
    chk(rd, (32'h1 << `SSRS_ST_BUS) | (32'h1 << `SSRS_ST_DEAD_BAT) | (32'h1 << `SSRS_ST_MR)
      | (32'h1 << `SSRS_ST_POWER_OK), "status");
    axw(`SSRS_ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    chk(irq, 0, "masked");
    report_and_stop;
  end
endmodule // tb_top
